// File: rtl/ramp_cfg.svh
`ifndef RAMP_CFG_SVH
`define RAMP_CFG_SVH

// register byte offsets
`define REG_TARGET 8'h00
`define REG_FLOOR 8'h04
`define REG_RISE 8'h08
`define REG_FALL 8'h0c
`define REG_SROUND 8'h10
`define REG_BAND 8'h14
`define REG_CTRL 8'h18
`define REG_OUTPUT 8'h1c
`define REG_STATUS 8'h20

// control field positions
`define CTRL_MAG_RATES 0
`define CTRL_AUTO_RESTART 1
`define CTRL_STANDSTILL 2
`define CTRL_FREEZE 3
`define CTRL_REMOTE_EN 4
`define CTRL_REMOTE_CMD 5
`define CTRL_WIDTH 6

// reset values (speed on network scale, 16'h7fff = 120 % speed)
`define RST_TARGET 16'h0000
`define RST_FLOOR 16'h0000
`define RST_RISE_DS 13'h0064
`define RST_FALL_DS 13'h0064
`define RST_SROUND 14'h01f4
`define RST_BAND 15'h0088
`define RST_CTRL 6'h03

// 100 % speed in network counts
`define FULL_SPEED 48'h6aaa
// rounding stretch: time * (20000 + 7 * s) / 20000, s in 0.01 %
`define SR_BASE 15'h4e20
`define SR_SLOPE 15'h0007
`define SR_SCALE 48'h4e20

// timing
`define CLK_PERIOD_NS 10
`define TICK_PERIOD_US 1000
`define DECISEC_NS 100000000

`endif

// File: rtl/ramp_pkg.sv
`default_nettype none
package ramp_pkg;
   typedef enum logic [1:0] {
      MODE_RAMP = 2'b00,
      MODE_HOLD = 2'b01,
      MODE_RESET = 2'b11
   } ramp_mode_e;
   typedef logic signed [15:0] speed_t;
endpackage
`default_nettype wire

// File: rtl/ramp_div.sv
`default_nettype none
module ramp_div #(
   parameter int W = 48
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic start,
   input wire logic [W-1:0] numer,
   input wire logic [W-1:0] denom,
   output logic done,
   output logic [W-1:0] quot
);
   logic [W:0] rem;
   logic [W-1:0] shq;
   logic [W-1:0] den;
   logic [6:0] cnt;
   logic busy;
   logic [W:0] trial;

   assign trial = {rem[W-1:0], shq[W-1]} - {1'b0, den};

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         busy <= 1'b0;
         cnt <= 7'h00;
         rem <= '0;
         shq <= '0;
         den <= '0;
      end else if (start && !busy) begin
         busy <= 1'b1;
         cnt <= 7'(W);
         rem <= '0;
         shq <= numer;
         den <= denom;
      end else if (busy) begin
         if (!trial[W]) begin
            rem <= trial;
         end else begin
            rem <= {rem[W-1:0], shq[W-1]};
         end
         shq <= {shq[W-2:0], !trial[W]};
         cnt <= cnt - 7'h01;
         if (cnt == 7'h01) begin
            busy <= 1'b0;
         end
      end
   end

   // result only moves when a division completes
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         quot <= '0;
         done <= 1'b0;
      end else begin
         done <= busy && (cnt == 7'h01);
         if (busy && (cnt == 7'h01)) begin
            quot <= {shq[W-2:0], !trial[W]};
         end
      end
   end
endmodule
`default_nettype wire

// File: rtl/speed_ramp_generator.sv
// Design decisions made here: the plain strobed port and the register addresses.
`include "ramp_cfg.svh"
`default_nettype none
module speed_ramp_generator
   import ramp_pkg::*;
#(
   parameter int TICK_CYCLES =
      `TICK_PERIOD_US * 1000 / `CLK_PERIOD_NS
) (
   input wire logic CORE_CLK,
   input wire logic RST_N,
   input wire logic [7:0] ADDR,
   input wire logic [31:0] WR_DATA,
   input wire logic WR_STB,
   input wire logic RD_STB,
   output logic [31:0] RD_DATA,
   input wire logic DRIVE_ENABLE,
   input wire logic ZERO_SPEED,
   output logic signed [15:0] RAMP_OUT,
   output logic SLEWING
);
   localparam int TICKS_PER_DS =
      (`DECISEC_NS / `CLK_PERIOD_NS) / TICK_CYCLES;
   localparam int TW = $clog2(TICK_CYCLES + 1);

   function automatic logic [15:0] mag16(input logic signed [15:0] v);
      logic [15:0] r;
      r = v[15] ? 16'(-v) : 16'(v);
      if (v == 16'sh8000) begin
         r = 16'h7fff;
      end
      return r;
   endfunction

   function automatic logic [47:0] ramp_den(input logic [12:0] t,
                                            input logic [13:0] s);
      logic [47:0] d;
      // widen before the sum: 7 * s alone overflows 15 bits at 100 %
      d = 48'(t == 13'h0000 ? 13'h0001 : t) *
          (48'(`SR_BASE) + 48'(`SR_SLOPE) * 48'(s)) *
          48'(TICKS_PER_DS);
      return d;
   endfunction

   function automatic logic [31:0] sat_step(input logic [47:0] q);
      return (q[47:31] != 17'h00000) ? 32'h7fffffff : q[31:0];
   endfunction

   // registers written by the network master
   speed_t target;
   speed_t floor_set;
   logic [12:0] rise_ds;
   logic [12:0] fall_ds;
   logic [13:0] s_round;
   logic [14:0] band;
   logic [`CTRL_WIDTH-1:0] ctrl;

   always_ff @(posedge CORE_CLK) begin
      if (!RST_N) begin
         target <= `RST_TARGET;
         floor_set <= `RST_FLOOR;
         rise_ds <= `RST_RISE_DS;
         fall_ds <= `RST_FALL_DS;
         s_round <= `RST_SROUND;
         band <= `RST_BAND;
         ctrl <= `RST_CTRL;
      end else if (WR_STB) begin
         case (ADDR)
            `REG_TARGET: target <= WR_DATA[15:0];
            `REG_FLOOR: floor_set <= WR_DATA[15:0];
            `REG_RISE: rise_ds <= WR_DATA[12:0];
            `REG_FALL: fall_ds <= WR_DATA[12:0];
            // above 100.00 % rounding is held at 100.00 %
            `REG_SROUND: s_round <= (WR_DATA[13:0] > 14'h2710) ?
                                    14'h2710 : WR_DATA[13:0];
            `REG_BAND: band <= WR_DATA[14:0];
            `REG_CTRL: ctrl <= WR_DATA[`CTRL_WIDTH-1:0];
            default: ;
         endcase
      end
   end

   // control tick
   logic [TW-1:0] tick_cnt;
   logic tick;
   assign tick = (tick_cnt == TW'(TICK_CYCLES - 1));

   always_ff @(posedge CORE_CLK) begin
      if (!RST_N) begin
         tick_cnt <= '0;
      end else if (tick) begin
         tick_cnt <= '0;
      end else begin
         tick_cnt <= tick_cnt + TW'(1);
      end
   end

   // step sizes, recomputed every tick so setting changes take effect
   logic [47:0] rise_q;
   logic [47:0] fall_q;
   logic [31:0] rise_step;
   logic [31:0] fall_step;

   ramp_div #(.W(48)) u_rise (
      .clk(CORE_CLK),
      .rst_n(RST_N),
      .start(tick),
      .numer(`FULL_SPEED * 48'h10000 * `SR_SCALE),
      .denom(ramp_den(rise_ds, s_round)),
      .done(),
      .quot(rise_q)
   );

   ramp_div #(.W(48)) u_fall (
      .clk(CORE_CLK),
      .rst_n(RST_N),
      .start(tick),
      .numer(`FULL_SPEED * 48'h10000 * `SR_SCALE),
      .denom(ramp_den(fall_ds, s_round)),
      .done(),
      .quot(fall_q)
   );

   assign rise_step = sat_step(rise_q);
   assign fall_step = sat_step(fall_q);

   // enable edge is remembered until the next tick
   logic enable_d;
   logic start_pend;

   always_ff @(posedge CORE_CLK) begin
      if (!RST_N) begin
         enable_d <= 1'b0;
         start_pend <= 1'b0;
      end else begin
         enable_d <= DRIVE_ENABLE;
         if (DRIVE_ENABLE && !enable_d) begin
            start_pend <= 1'b1;
         end else if (tick) begin
            start_pend <= 1'b0;
         end
      end
   end

   // floor clamp on the target, only while enabled
   logic [15:0] floor_mag;
   speed_t floor_val;
   speed_t tgt;
   assign floor_mag = mag16(floor_set);
   assign floor_val = target[15] ? 16'(-floor_mag) : 16'(floor_mag);
   assign tgt = (DRIVE_ENABLE && mag16(target) < floor_mag) ?
                floor_val : target;

   logic reset_req;
   logic mag_rates;
   logic freeze;
   assign mag_rates = ctrl[`CTRL_MAG_RATES];
   assign freeze = ctrl[`CTRL_FREEZE];
   assign reset_req =
      (ctrl[`CTRL_REMOTE_EN] && ctrl[`CTRL_REMOTE_CMD]) ||
      (ctrl[`CTRL_AUTO_RESTART] && start_pend) ||
      (ctrl[`CTRL_STANDSTILL] && ZERO_SPEED);

   ramp_mode_e mode;
   always_comb begin
      if (reset_req) begin
         mode = MODE_RESET;
      end else if (freeze) begin
         mode = MODE_HOLD;
      end else begin
         mode = MODE_RAMP;
      end
   end

   // output accumulator: 16 bits of speed over 16 bits of fraction
   logic signed [31:0] acc;
   logic signed [31:0] tgt_acc;
   logic up;
   logic grows;
   logic [31:0] sel_step;
   logic signed [32:0] sum;
   logic signed [31:0] next_acc;

   assign RAMP_OUT = acc[31:16];
   assign tgt_acc = {tgt, 16'h0000};
   assign up = tgt_acc > acc;
   // magnitude grows when moving away from zero
   assign grows = acc[31] ? !up : up;
   assign sel_step = (mag_rates ? grows : up) ?
                     rise_step : fall_step;

   always_comb begin
      sum = up ? 33'(acc) + 33'(sel_step) : 33'(acc) - 33'(sel_step);
      if (up) begin
         next_acc = (sum > 33'(tgt_acc)) ? tgt_acc : 32'(sum);
      end else begin
         next_acc = (sum < 33'(tgt_acc)) ? tgt_acc : 32'(sum);
      end
   end

   always_ff @(posedge CORE_CLK) begin
      if (!RST_N) begin
         acc <= 32'sh00000000;
      end else if (tick) begin
         case (mode)
            MODE_RESET: acc <= {floor_val, 16'h0000};
            MODE_HOLD: acc <= acc;
            MODE_RAMP: acc <= next_acc;
            default: acc <= acc;
         endcase
      end
   end

   logic signed [16:0] err;
   logic [16:0] err_mag;
   assign err = 17'(RAMP_OUT) - 17'(tgt);
   assign err_mag = err[16] ? 17'(-err) : 17'(err);

   always_ff @(posedge CORE_CLK) begin
      if (!RST_N) begin
         SLEWING <= 1'b0;
      end else begin
         SLEWING <= (mode == MODE_RAMP) && (err_mag > 17'(band));
      end
   end

   // read port: data only in the cycle after the strobe
   always_ff @(posedge CORE_CLK) begin
      if (!RST_N) begin
         RD_DATA <= 32'h00000000;
      end else if (RD_STB) begin
         case (ADDR)
            `REG_TARGET: RD_DATA <= {16'h0000, target};
            `REG_FLOOR: RD_DATA <= {16'h0000, floor_set};
            `REG_RISE: RD_DATA <= {19'h00000, rise_ds};
            `REG_FALL: RD_DATA <= {19'h00000, fall_ds};
            `REG_SROUND: RD_DATA <= {18'h00000, s_round};
            `REG_BAND: RD_DATA <= {17'h00000, band};
            `REG_CTRL: RD_DATA <= {26'h0000000, ctrl};
            `REG_OUTPUT: RD_DATA <= {16'h0000, RAMP_OUT};
            `REG_STATUS: RD_DATA <= {28'h0000000, mode, freeze, SLEWING};
            default: RD_DATA <= 32'h00000000;
         endcase
      end else begin
         RD_DATA <= 32'h00000000;
      end
   end

   remote_reset_a: assert property (
      @(posedge CORE_CLK) disable iff (!RST_N)
      tick && ctrl[4] && ctrl[5] |=> RAMP_OUT == $past(floor_val))
      else $error("remote restart did not load floor");

   resume_a: assert property (
      @(posedge CORE_CLK) disable iff (!RST_N)
      tick && mode == MODE_RAMP && up && rise_step != 0 &&
      fall_step != 0 |=> acc > $past(acc))
      else $error("ramp did not move toward target");

   floor_clamp_a: assert property (
      @(posedge CORE_CLK) disable iff (!RST_N)
      DRIVE_ENABLE |-> mag16(tgt) >= floor_mag)
      else $error("clamped target below floor");

   freeze_hold_a: assert property (
      @(posedge CORE_CLK) disable iff (!RST_N)
      tick && freeze && !reset_req |=> $stable(acc))
      else $error("output moved while frozen");

   start_reset_a: assert property (
      @(posedge CORE_CLK) disable iff (!RST_N)
      tick && ctrl[1] && start_pend |=> RAMP_OUT == $past(floor_val))
      else $error("start did not reset to floor");

   stop_no_reset_a: assert property (
      @(posedge CORE_CLK) disable iff (!RST_N)
      $fell(DRIVE_ENABLE) && !start_pend |=> !start_pend)
      else $error("disabling latched a restart");

   slew_flag_a: assert property (
      @(posedge CORE_CLK) disable iff (!RST_N)
      freeze |=> !SLEWING)
      else $error("slewing reported while frozen");

   no_overshoot_a: assert property (
      @(posedge CORE_CLK) disable iff (!RST_N)
      tick && mode == MODE_RAMP && up |=> acc <= $past(tgt_acc))
      else $error("ramp overshot target");

   rate_select_a: assert property (
      @(posedge CORE_CLK) disable iff (!RST_N)
      !mag_rates && !up |-> sel_step == fall_step)
      else $error("two quadrant fall rate not used");

   quad_select_a: assert property (
      @(posedge CORE_CLK) disable iff (!RST_N)
      mag_rates && acc[31] && !up |-> sel_step == rise_step)
      else $error("negative growth did not use rise rate");

   standstill_a: assert property (
      @(posedge CORE_CLK) disable iff (!RST_N)
      tick && ctrl[2] && ZERO_SPEED |=> RAMP_OUT == $past(floor_val))
      else $error("standstill restart ignored");

   step_bound_a: assert property (
      @(posedge CORE_CLK) disable iff (!RST_N)
      tick && mode == MODE_RAMP && up |=>
      acc - $past(acc) <= $signed({1'b0, $past(sel_step)}))
      else $error("ramp step larger than rate");

   band_flag_a: assert property (
      @(posedge CORE_CLK) disable iff (!RST_N)
      mode == MODE_RAMP && err_mag > 17'(band) |=> SLEWING)
      else $error("slewing not reported above band");

   tick_only_a: assert property (
      @(posedge CORE_CLK) disable iff (!RST_N)
      !tick |=> $stable(acc))
      else $error("output moved between ticks");
endmodule
`default_nettype wire

// File: testbench/net_master.sv
`include "ramp_cfg.svh"
`default_nettype none
module net_master (
   input wire logic clk,
   output logic [7:0] addr,
   output logic [31:0] wr_data,
   output logic wr_stb,
   output logic rd_stb,
   input wire logic [31:0] rd_data
);
   timeunit 1ns;
   timeprecision 100ps;
   initial begin
      addr = 8'h00;
      wr_data = 32'h0;
      wr_stb = 1'b0;
      rd_stb = 1'b0;
   end
   // one-cycle strobes, the slave never stalls
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      addr <= a;
      wr_data <= d;
      wr_stb <= 1'b1;
      @(posedge clk);
      wr_stb <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk);
      addr <= a;
      rd_stb <= 1'b1;
      @(posedge clk);
      rd_stb <= 1'b0;
      @(posedge clk);
      d = rd_data;
   endtask
   // caller hands counts already prescaled, 16'h6aaa is rated speed
   task automatic send_ref(input int counts);
      wr(`REG_TARGET, 32'(counts));
   endtask
endmodule
`default_nettype wire

// File: testbench/tb.sv
`include "ramp_cfg.svh"
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 100ps;
   localparam int TICK = 200;
   localparam int TPD = `DECISEC_NS / (`CLK_PERIOD_NS * TICK);
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic en = 1'b0;
   logic zs = 1'b0;
   logic [7:0] addr;
   logic [31:0] wr_data;
   logic [31:0] rd_data;
   logic wr_stb;
   logic rd_stb;
   logic slewing;
   logic signed [15:0] ramp_out;
   int n_mismatch = 0;
   int checked = 0;
   int cycles = 0;
   int a;
   int b;
   logic [31:0] seed = 32'h50dafbf0;
   logic [31:0] v;
   logic [31:0] r;
   logic [31:0] dflt [$] = '{32'h0, 32'h0, 32'h64, 32'h64, 32'h1f4,
      32'h88, 32'h3, 32'h0, 32'h0, 32'h0};
   always #(`CLK_PERIOD_NS / 2) clk = ~clk;
   speed_ramp_generator #(.TICK_CYCLES(TICK)) dut_u (
      .CORE_CLK(clk), .RST_N(rst_n), .ADDR(addr), .WR_DATA(wr_data),
      .WR_STB(wr_stb), .RD_STB(rd_stb), .RD_DATA(rd_data),
      .DRIVE_ENABLE(en), .ZERO_SPEED(zs), .RAMP_OUT(ramp_out),
      .SLEWING(slewing));
   net_master net_u (.clk(clk), .addr(addr), .wr_data(wr_data),
      .wr_stb(wr_stb), .rd_stb(rd_stb), .rd_data(rd_data));
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   function automatic int out();
      return int'(ramp_out);
   endfunction
   // expected movement over n ticks, linear profile stretched by rounding
   function automatic int steps(int n, int t, int s);
      return $rtoi(n * 27306.0 / (t * TPD * (1.0 + 3.5 * s / 10000.0)));
   endfunction
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // fixed-point truncation in the step may cost a count or two
   task automatic near(input int seen, input int exp);
      check(32'(seen), (seen - exp) inside {[-2:2]} ? 32'(seen) : 32'(exp));
   endtask
   task automatic ticks(input int n);
      repeat (n * TICK) @(posedge clk);
   endtask
   task automatic finish_test();
      $display("comparisons %0d mismatches %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 70000) begin
         n_mismatch++;
         finish_test();
      end
   end
   initial begin
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      for (int i = 0; i < 10; i++) begin
         net_u.rd(8'(4 * i), r);
         check(r, dflt[i]);
      end
      repeat (4) begin
         v = rnd() & 32'h7fff;
         net_u.wr(`REG_BAND, v);
         net_u.rd(`REG_BAND, r);
         check(r, v);
      end
      net_u.wr(`REG_SROUND, 32'hffff);
      net_u.rd(`REG_SROUND, r);
      check(r, 32'h2710);
      net_u.wr(`REG_OUTPUT, 32'h1234);
      net_u.rd(`REG_OUTPUT, r);
      check(r, 32'h0);
      $display("test registers done");
      net_u.wr(`REG_SROUND, 32'h0);
      net_u.wr(`REG_BAND, 32'h4);
      net_u.wr(`REG_RISE, 32'h1);
      net_u.wr(`REG_FALL, 32'h2);
      net_u.wr(`REG_FLOOR, 32'h64);
      net_u.send_ref(300);
      net_u.wr(`REG_CTRL, 32'h33);
      en <= 1'b1;
      ticks(3);
      check(32'(out()), 32'h64);
      check(32'(slewing), 32'h0);
      net_u.rd(`REG_STATUS, r);
      check(r, 32'hc);
      net_u.wr(`REG_CTRL, 32'h13);
      ticks(2);
      a = out();
      near(a, 100);
      ticks(30);
      b = out();
      near(b - a, steps(30, 1, 0));
      check(32'(slewing), 32'h1);
      $display("test remote restart done");
      net_u.wr(`REG_CTRL, 32'h1b);
      ticks(2);
      a = out();
      net_u.send_ref(-300);
      ticks(10);
      check(32'(out()), 32'(a));
      check(32'(slewing), 32'h0);
      net_u.wr(`REG_CTRL, 32'h3b);
      ticks(2);
      check(32'(out()), -32'sd100);
      net_u.wr(`REG_CTRL, 32'h1b);
      ticks(3);
      check(32'(out()), -32'sd100);
      net_u.wr(`REG_CTRL, 32'h13);
      ticks(2);
      a = out();
      near(a, -100);
      ticks(30);
      b = out();
      near(a - b, steps(30, 1, 0));
      $display("test freeze done");
      net_u.wr(`REG_CTRL, 32'h12);
      ticks(2);
      a = out();
      ticks(30);
      b = out();
      near(a - b, steps(30, 2, 0));
      $display("test two quadrant done");
      en <= 1'b0;
      net_u.wr(`REG_CTRL, 32'h13);
      net_u.send_ref(0);
      ticks(2);
      a = out();
      near(a, b);
      ticks(30);
      b = out();
      near(b - a, steps(30, 2, 0));
      en <= 1'b1;
      ticks(2);
      check(32'(out()), 32'h64);
      net_u.send_ref(20);
      ticks(5);
      check(32'(out()), 32'h64);
      $display("test enable done");
      net_u.send_ref(300);
      net_u.wr(`REG_CTRL, 32'h17);
      ticks(10);
      near(out() - 100, steps(10, 1, 0));
      zs <= 1'b1;
      ticks(2);
      check(32'(out()), 32'h64);
      zs <= 1'b0;
      $display("test standstill done");
      net_u.wr(`REG_SROUND, 32'd10000);
      net_u.wr(`REG_CTRL, 32'h13);
      ticks(2);
      a = out();
      ticks(30);
      b = out();
      near(b - a, steps(30, 1, 10000));
      $display("test rounding done");
      finish_test();
   end
endmodule
`default_nettype wire
